// ### logic/route_frame_defines.svh
// Purpose: Byte values, positions and limits of the route creation frame.
// Assumes: Included by both ends, the parser and the sender.
// Notes: Definitions only.
`ifndef ROUTE_FRAME_DEFINES_SVH
`define ROUTE_FRAME_DEFINES_SVH
`define START_DELIM 8'h7e
`define TYPE_ROUTE 8'h21
`define MAX_HOPS 8'h1e
`define FIXED_BYTES 16'h000e
`define CSUM_GOOD 8'hff
`define POS_TYPE 6'h00
`define POS_ID 6'h01
`define POS_LONG 6'h02
`define POS_SHORT 6'h0a
`define POS_OPT 6'h0c
`define POS_COUNT 6'h0d
`define POS_HOPS 6'h0e
`endif

// ### logic/route_frame_pkg.sv
// Purpose: Types shared by both ends of the route creation link.
// Assumes: Byte-wide link with valid and ready.
// Notes: Hop list is sized for the largest route.
package route_frame_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] addr16_t;
    typedef logic [63:0] addr64_t;
    typedef logic [4:0] hop_idx_t;
    typedef struct packed {
        addr64_t long_addr;
        addr16_t short_addr;
        logic [7:0] hop_count;
        logic [30*16-1:0] hops;
    } route_entry_s;
endpackage : route_frame_pkg

// ### logic/route_link_if.sv
// Purpose: Byte stream from host controller to device.
// Assumes: Single clock, byte moves when valid and ready are both high.
// Notes: No path back carries frames; the device never answers.
`timescale 1ns/1ns
interface route_link_if (
    input wire logic clk
);
    logic [7:0] data;
    logic valid;
    logic ready;
    modport host (input clk, output data, output valid, input ready);
    modport device (input clk, input data, input valid, output ready);
endinterface : route_link_if

// ### logic/frame_checksum.sv
// Purpose: Running byte sum for the frame checksum.
// Assumes: clear pulses before the first summed byte.
// Notes: Shared by both ends.
`timescale 1ns/1ns
module frame_checksum (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] sum
);
    logic [7:0] next_sum;

    // Sum wraps modulo 256, which is all the check needs.
    always_comb
    begin
        next_sum = sum;
        if (clear)
            next_sum = 8'h00;
        else if (add)
            next_sum = sum + data;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            sum <= 8'h00;
        else
            sum <= next_sum;
    end
endmodule : frame_checksum

// ### logic/route_frame_parser.sv
// Purpose: Device end; parses route creation frames and emits checked entries.
// Assumes: Host keeps its side of the format; link on the same clock.
// Notes: Bad frames vanish without trace; nothing is ever sent back.
// Behaviour
// - Frame begins with start delimiter byte.
// - Sixteen-bit length locates the checksum.
// - Type 0x21 goes to entry writer.
// - Device never sends any response frame.
// - Host puts zero in frame identifier.
// - Host supplies long and short destination.
// - Bytes from 5 are long destination.
// - Bytes from 13 are short destination.
// - Options byte is zero, ignored here.
// - Byte 16 counts intermediate hops.
// - Hop count zero or above thirty dropped.
// - Hops from 17, destination side first.
// - Checksum is 0xff minus byte sum.
// - Malformed requests rejected silently.
`timescale 1ns/1ns
`include "route_frame_defines.svh"
module route_frame_parser (
    input wire logic clk,
    input wire logic rstn,
    route_link_if.device link,
    output logic entry_valid,
    output route_frame_pkg::route_entry_s entry
);
    import route_frame_pkg::*;

    typedef enum logic [2:0] {
        HUNT = 3'b000,
        LEN_HI = 3'b001,
        LEN_LO = 3'b010,
        BODY = 3'b011,
        CSUM = 3'b100
    } parse_e;

    parse_e state, next_state;
    logic [15:0] len, next_len;
    logic [15:0] pos, next_pos;
    logic bad, next_bad;
    route_entry_s work, next_work;
    route_entry_s next_entry;
    logic next_entry_valid;
    logic take;
    logic sum_clear;
    logic sum_add;
    logic [7:0] sum;
    logic [7:0] total;
    logic at_type;
    logic in_long;
    logic in_short;
    logic at_count;
    logic in_hops;
    logic count_bad;
    logic len_match;
    logic sum_match;
    logic frame_good;

    // The device end always accepts; it has no buffer to fill.
    assign link.ready = 1'b1;
    assign take = link.valid;
    assign total = sum + link.data;

    // Field decode by body position; position zero is the frame type byte.
    assign at_type = (pos == 16'({10'h000, `POS_TYPE}));
    assign in_long = (pos >= 16'({10'h000, `POS_LONG})) && (pos < 16'({10'h000, `POS_SHORT}));
    assign in_short = (pos >= 16'({10'h000, `POS_SHORT})) && (pos < 16'({10'h000, `POS_OPT}));
    assign at_count = (pos == 16'({10'h000, `POS_COUNT}));
    // Hop bytes run to the end of the body; surplus bytes are caught by the length check.
    assign in_hops = (pos >= 16'({10'h000, `POS_HOPS})) && (pos < len);
    // Zero hops is no source route, and the table holds no route longer than the limit.
    assign count_bad = (link.data == 8'h00) || (link.data > `MAX_HOPS);
    // Length must cover exactly the fixed fields and the hop list, else the entry is junk.
    assign len_match = (len == `FIXED_BYTES + {7'h00, work.hop_count, 1'b0});
    // An intact frame brings the byte sum, checksum included, to all ones.
    assign sum_match = (total == `CSUM_GOOD);
    assign frame_good = !bad && sum_match && len_match;

    frame_checksum i_frame_checksum (
        .clk(clk),
        .rstn(rstn),
        .clear(sum_clear),
        .add(sum_add),
        .data(link.data),
        .sum(sum)
    );

    // Byte walker; fields land in the working entry by position.
    always_comb
    begin
        next_state = state;
        next_len = len;
        next_pos = pos;
        next_bad = bad;
        next_work = work;
        sum_clear = 1'b0;
        sum_add = 1'b0;
        if (take)
        begin
            case (state)
                HUNT:
                begin
                    // Any byte but the delimiter is skipped, so a lost frame resyncs.
                    if (link.data == `START_DELIM)
                        next_state = LEN_HI;
                    sum_clear = 1'b1;
                end
                LEN_HI:
                begin
                    // The length travels high byte first.
                    next_len = {link.data, 8'h00};
                    next_state = LEN_LO;
                end
                LEN_LO:
                begin
                    // A fresh frame starts from an empty entry; an empty body is skipped.
                    next_len = {len[15:8], link.data};
                    next_pos = 16'h0000;
                    next_bad = 1'b0;
                    next_work = '0;
                    next_state = ({len[15:8], link.data} == 16'h0000) ? HUNT : BODY;
                end
                BODY:
                begin
                    // Every body byte feeds the sum, identifier and options too.
                    sum_add = 1'b1;
                    if (at_type && link.data != `TYPE_ROUTE)
                        next_bad = 1'b1;
                    if (in_long)
                        next_work.long_addr = {work.long_addr[55:0], link.data};
                    if (in_short)
                        next_work.short_addr = {work.short_addr[7:0], link.data};
                    if (at_count)
                    begin
                        next_work.hop_count = link.data;
                        if (count_bad)
                            next_bad = 1'b1;
                    end
                    // Hops shift in so the first hop ends up in the top used slot.
                    if (in_hops)
                        next_work.hops = {work.hops[30*16-9:0], link.data};
                    next_pos = pos + 16'h0001;
                    if (pos + 16'h0001 == len)
                        next_state = CSUM;
                end
                CSUM:
                begin
                    // Pass or fail, hunting starts again; a failure leaves no trace.
                    next_state = HUNT;
                end
                default:
                    next_state = HUNT;
            endcase
        end
    end

    // Frame identifier and options are read past, never used.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state <= HUNT;
            len <= 16'h0000;
            pos <= 16'h0000;
            bad <= 1'b0;
            work <= '0;
        end
        else
        begin
            state <= next_state;
            len <= next_len;
            pos <= next_pos;
            bad <= next_bad;
            work <= next_work;
        end
    end

    // The entry only changes on a frame that passed every check, so a
    // rejected frame cannot disturb the route last written.
    always_comb
    begin
        next_entry = entry;
        next_entry_valid = 1'b0;
        if (take && state == CSUM && frame_good)
        begin
            next_entry = work;
            next_entry_valid = 1'b1;
        end
    end

    // Result registers; the valid pulse lasts one cycle.
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            entry <= '0;
            entry_valid <= 1'b0;
        end
        else
        begin
            entry <= next_entry;
            entry_valid <= next_entry_valid;
        end
    end
endmodule : route_frame_parser

// ### logic/route_frame_sender.sv
// Purpose: Host end; serialises one route entry into a framed byte stream.
// Assumes: User holds the request fields stable while busy.
// Notes: Hop count is sent as given, so bad counts can be exercised.
`timescale 1ns/1ns
`include "route_frame_defines.svh"
module route_frame_sender (
    input wire logic clk,
    input wire logic rstn,
    route_link_if.host link,
    input wire logic send,
    input route_frame_pkg::route_entry_s req,
    output logic busy
);
    import route_frame_pkg::*;

    logic [15:0] idx, next_idx;
    logic next_busy;
    logic [15:0] len;
    logic [15:0] last;
    logic [7:0] byte_out;
    logic [7:0] sum;
    logic [15:0] body;
    logic [8:0] hop_bit;
    logic step;

    assign len = `FIXED_BYTES + {7'h00, req.hop_count, 1'b0};
    assign last = len + 16'h0003;
    assign body = idx - 16'h0003;
    assign step = busy && link.ready;
    assign hop_bit = 9'(479 - 8 * (body - 16'({10'h000, `POS_HOPS})));

    frame_checksum i_frame_checksum (
        .clk(clk),
        .rstn(rstn),
        .clear(send && !busy),
        .add(step && idx >= 16'h0003 && idx < last),
        .data(byte_out),
        .sum(sum)
    );

    // Pick the byte for the current position.
    always_comb
    begin
        byte_out = 8'h00;
        if (idx == 16'h0000)
            byte_out = `START_DELIM;
        else if (idx == 16'h0001)
            byte_out = len[15:8];
        else if (idx == 16'h0002)
            byte_out = len[7:0];
        else if (idx == last)
            byte_out = `CSUM_GOOD - sum;
        else if (body == 16'({10'h000, `POS_TYPE}))
            byte_out = `TYPE_ROUTE;
        else if (body < 16'({10'h000, `POS_SHORT}) && body >= 16'({10'h000, `POS_LONG}))
            byte_out = req.long_addr[8*(9 - body[3:0]) +: 8];
        else if (body < 16'({10'h000, `POS_OPT}) && body >= 16'({10'h000, `POS_SHORT}))
            byte_out = req.short_addr[8*(11 - body[3:0]) +: 8];
        else if (body == 16'({10'h000, `POS_COUNT}))
            byte_out = req.hop_count;
        // Past the longest legal route there is no hop to read, so zero goes out.
        else if (body >= 16'({10'h000, `POS_HOPS})
            && body - 16'({10'h000, `POS_HOPS}) < 16'({7'h00, `MAX_HOPS, 1'b0}))
            byte_out = req.hops[hop_bit -: 8];
        // Frame identifier and options stay zero.
    end

    assign link.valid = busy;
    assign link.data = byte_out;

    // Walk the frame one byte per accepted transfer.
    always_comb
    begin
        next_busy = busy;
        next_idx = idx;
        if (!busy && send)
        begin
            next_busy = 1'b1;
            next_idx = 16'h0000;
        end
        else if (step)
        begin
            next_idx = idx + 16'h0001;
            if (idx == last)
                next_busy = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            busy <= 1'b0;
            idx <= 16'h0000;
        end
        else
        begin
            busy <= next_busy;
            idx <= next_idx;
        end
    end
endmodule : route_frame_sender

// ### verification/route_link_assertions.sv
// Purpose: Wire checks on the link between sender and parser.
// Assumes: Frames come whole, one byte a cycle.
// Notes: n is the byte index within the frame.
`timescale 1ns/1ns
module route_link_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic ready
);
    logic [7:0] n;
    logic [7:0] len;
    logic [7:0] sum;
    wire tk = valid && ready;
    wire last = tk && n > 8'h02 && n == len + 8'h03;
    // Tracks the index, length and running sum, so that a slip in framing shows.
    always_ff @(posedge clk)
    begin
        if (!rstn || last)
        begin
            n <= 8'h00;
            sum <= 8'h00;
        end
        else if (tk)
        begin
            n <= n + 8'h01;
            len <= (n == 8'h02) ? data : len;
            sum <= (n > 8'h02) ? sum + data : sum;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_DELIM: assert property (tk && n == 8'h00 |-> data == 8'h7e)
        else $error("frame does not open with the delimiter");
    AST_LEN_HI: assert property (tk && n == 8'h01 |-> data == 8'h00)
        else $error("length high byte not zero");
    AST_TYPE: assert property (tk && n == 8'h03 |-> data == 8'h21)
        else $error("wrong frame type");
    AST_ID: assert property (tk && n == 8'h04 |-> data == 8'h00)
        else $error("frame identifier not zero");
    AST_OPT: assert property (tk && n == 8'h0f |-> data == 8'h00)
        else $error("options byte not zero");
    AST_HOPLEN: assert property (tk && n == 8'h10 |-> len == 8'h0e + (data << 1))
        else $error("length disagrees with hop count");
    AST_SUM: assert property (last |-> 8'(sum + data) == 8'hff)
        else $error("checksum wrong");
    AST_GAPLESS: assert property (tk && !last |=> valid)
        else $error("gap inside a frame");
    cover property (last);
    cover property (tk && n == 8'h10 && data == 8'h1e);
    cover property (tk && n == 8'h10 && data == 8'h00);
endmodule : route_link_assertions

// ### verification/source_route_frame_parser_test.sv
// Purpose: Self-checking bench for both ends of the route link.
// Assumes: The sender derives the length from the hop count.
// Notes: A second parser takes hand-made frames, faulty and intact.
`timescale 1ns/1ns
module source_route_frame_parser_test;
    import route_frame_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic send = 1'b0;
    route_entry_s req = '0;
    logic busy;
    logic entry_valid;
    logic ev2;
    route_entry_s entry;
    route_entry_s e2;
    route_entry_s q1[$];
    route_entry_s q2[$];
    byte_t fb[$];
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int hop_counts[6] = '{1, 30, 0, 31, 2, 29};
    route_link_if link (.clk(clk));
    route_link_if bad (.clk(clk));
    route_frame_sender i_route_frame_sender (.clk(clk), .rstn(rstn), .link(link.host),
        .send(send), .req(req), .busy(busy));
    route_frame_parser i_route_frame_parser (.clk(clk), .rstn(rstn), .link(link.device),
        .entry_valid(entry_valid), .entry(entry));
    route_frame_parser i_route_frame_parser_faulty (.clk(clk), .rstn(rstn),
        .link(bad.device), .entry_valid(ev2), .entry(e2));
    route_link_assertions i_route_link_assertions (.clk(clk), .rstn(rstn),
        .data(link.data), .valid(link.valid), .ready(link.ready));
    always #25 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input route_entry_s seen, input route_entry_s exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // Hops above the route are masked: the parser need not clear them.
    task automatic watch(input string what, input route_entry_s seen, ref route_entry_s q[$]);
        route_entry_s x;
        if (q.size() == 0)
        begin
            miscompares++;
            $display("unexpected %s: expected none, seen %h", what, seen);
            return;
        end
        x = q.pop_front();
        seen.hops &= {480{1'b1}} >> (16 * (30 - x.hop_count));
        check(what, seen, x);
    endtask : watch
    // Each entry pulse retires the oldest note; the cycle count cuts a hang.
    always @(negedge clk)
    begin
        if (entry_valid === 1'b1)
            watch("entry", entry, q1);
        if (ev2 === 1'b1)
            watch("faulty link entry", e2, q2);
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // Random entry through the sender; bad hop counts must give nothing.
    task automatic send_route(input int n);
        route_entry_s r;
        int t;
        r.long_addr = {$urandom(), $urandom()};
        r.short_addr = 16'($urandom());
        r.hop_count = 8'(n);
        for (int k = 0; k < 15; k++)
            r.hops[32*k+:32] = $urandom();
        if (n > 0 && n <= 30)
            q1.push_back({r.long_addr, r.short_addr, r.hop_count,
                r.hops >> (16 * (30 - n))});
        @(negedge clk);
        req = r;
        send = 1'b1;
        @(negedge clk);
        send = 1'b0;
        t = 0;
        while (busy !== 1'b0 && t < 200)
        begin
            @(negedge clk);
            t++;
        end
    endtask : send_route
    // Hand-made frame after a stray byte; hop bytes avoid the delimiter value.
    task automatic put(input int n, input byte_t ft, input byte_t flip, input int adj);
        byte_t s;
        route_entry_s x;
        x = {64'h0123456789abcdef, 16'h4321, 8'(n), 480'h0};
        fb = {8'h55, 8'h7e, 8'h00, 8'(14 + 2 * n + adj), ft, 8'h00};
        for (int i = 7; i >= 0; i--)
            fb.push_back(x.long_addr[8*i+:8]);
        fb = {fb, 8'h43, 8'h21, 8'h00, 8'(n)};
        for (int k = 0; k < 2 * n; k++)
            fb.push_back(8'h24 + 8'(k));
        for (int k = 0; k < n && k < 30; k++)
            x.hops[16*(n-1-k)+:16] = {8'h24 + 8'(2 * k), 8'h25 + 8'(2 * k)};
        for (int k = 0; k < adj; k++)
            fb.push_back(8'h33);
        s = 8'h00;
        foreach (fb[i])
            s += (i > 3) ? fb[i] : 8'h00;
        fb.push_back((8'hff - s) ^ flip);
        if (ft == 8'h21 && flip == 8'h00 && adj == 0 && n > 0 && n <= 30)
            q2.push_back(x);
        foreach (fb[i])
        begin
            @(negedge clk);
            bad.valid = 1'b1;
            bad.data = fb[i];
            do @(posedge clk); while (bad.ready !== 1'b1);
        end
        @(negedge clk);
        bad.valid = 1'b0;
        bad.data = ~bad.data;
    endtask : put
    initial
    begin
        bad.valid = 1'b0;
        bad.data = 8'h00;
        void'($urandom(8668));
        repeat (20) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        foreach (hop_counts[i])
            send_route(hop_counts[i]);
        repeat (4) send_route(1 + $urandom_range(29));
        put(3, 8'h21, 8'h00, 0);
        put(3, 8'h21, 8'h01, 0);
        put(3, 8'h24, 8'h00, 0);
        put(3, 8'h21, 8'h00, 2);
        put(0, 8'h21, 8'h00, 0);
        put(31, 8'h21, 8'h00, 0);
        put(30, 8'h21, 8'h00, 0);
        repeat (10) @(negedge clk);
        checks++;
        if (q1.size() + q2.size() != 0)
        begin
            miscompares++;
            $display("unexpected pending entries: expected 0, seen %0d", q1.size() + q2.size());
        end
        stop_test();
    end
endmodule : source_route_frame_parser_test
